// ==== timer_pkg.sv ====
// Constants, types and field layouts shared by the dual half timer
// Summary of operation
// - Config 0 wide timer, 1 wide clock
// - Config 0x4 gives two independent halves
// - Wide load write splits high/low halves
// - Wide count reads B high, A low
// - Wide timer uses only half A mode
// - Wide timer counts down, reloads after zero
// - Timeout sets sticky raw, masked, interrupt
// - Timeout triggers converter only when enabled
// - Load write reaches counter next cycle, except in clock mode
// - Debug stall freezes counter during halt
// - Clock mode counts up, starts at one
// - Pin clock divided down to 1 Hz
// - Clock match rolls count over to zero
// - Clock match sets flags, clear bit clears
// - Stall override keeps clock running in halt
// - Half unit: 16-bit down, 8-bit prescale
// - Half unit reloads count and prescale
// - Prescale p gives p+1 clocks per step
// - Edge count uses selected edges, no prescale
// - Each edge decrements; match sets flags
// - Match reloads, clears enable, ignores edges
// - Reset: counts, loads 0xFFFF, prescale 0x00
// - Mode 0x1 one-shot, 0x2 periodic
// - Capture bit 0, mode 0x3 edge count
package timer_pkg;

    // Width configuration values
    typedef enum logic [2:0] {
        CFG_32_TIMER = 3'h0,
        CFG_32_CLOCK = 3'h1,
        CFG_16_SPLIT = 3'h4
    } width_cfg_e;

    // Unit mode field values
    localparam logic [1:0] MODE_ONESHOT  = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE  = 2'h3;
    localparam logic       CMR_EDGE_CNT  = 1'h0;

    // Edge select encoding
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Reset and load values
    localparam logic [15:0] CNT_RST    = 16'hFFFF;
    localparam logic [15:0] LOAD_RST   = 16'hFFFF;
    localparam logic [15:0] MATCH_RST  = 16'hFFFF;
    localparam logic [7:0]  PRE_RST    = 8'h00;
    localparam logic [15:0] ZERO16     = 16'h0000;
    localparam logic [7:0]  ZERO8      = 8'h00;
    localparam logic [31:0] ZERO32     = 32'h0000_0000;
    localparam logic [31:0] CLOCK_START = 32'h0000_0001;

    // Pin clock and divided rate
    localparam int CLOCK_IN_HZ  = 32768;
    localparam int CLOCK_OUT_HZ = 1;
    localparam int CLOCK_DIV    = CLOCK_IN_HZ / CLOCK_OUT_HZ;

    // Status bit positions: timeouts, capture matches, clock match
    localparam int ST_TO    = 0;
    localparam int ST_CM    = 2;
    localparam int ST_CLOCK = 4;
    localparam int ST_W     = 5;

    // Per-unit configuration
    typedef struct packed {
        logic [1:0] mode;
        logic       capture_mode;
        logic [1:0] edge_sel;
        logic       trig_en;
        logic       debug_stall;
    } unit_cfg_s;

endpackage

// ==== timer_pair.sv ====
// Dual 16-bit timer halves with wide, clock and edge count modes
module timer_pair #(
    parameter int CLOCK_DIV = timer_pkg::CLOCK_DIV
) (
    // Clock, reset, enable
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_ce,
    // Configuration levels
    input  wire timer_pkg::width_cfg_e        i_width_cfg,
    input  wire timer_pkg::unit_cfg_s [1:0]   i_unit_cfg,
    input  wire logic                         i_clock_stall_override,
    input  wire logic                         i_dbg_halt,
    input  wire logic [timer_pkg::ST_W-1:0]   i_irq_mask,
    // Software strobes
    input  wire logic [1:0]                   i_enable_set,
    input  wire logic [1:0]                   i_enable_clr,
    input  wire logic [1:0]                   i_load_wr,
    input  wire logic [1:0]                   i_match_wr,
    input  wire logic [1:0]                   i_prescale_wr,
    input  wire logic [31:0]                  i_wr_data,
    input  wire logic [timer_pkg::ST_W-1:0]   i_irq_clear,
    // Capture pins, index 0 is the even pin
    input  wire logic [1:0]                   i_capture_pin,
    // Status and counts
    output logic [1:0]                        o_unit_enable,
    output logic [15:0]                       o_half_a_count,
    output logic [15:0]                       o_half_b_count,
    output logic [31:0]                       o_wide_count,
    output logic [timer_pkg::ST_W-1:0]        o_raw_status,
    output logic [timer_pkg::ST_W-1:0]        o_masked_status,
    output logic                              o_irq,
    output logic                              o_adc_trig
);

    localparam int DW = $clog2(CLOCK_DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(CLOCK_DIV - 1);

    logic [1:0][15:0] cnt_q, cnt_d, u_cnt_d, load_q, match_q;
    logic [1:0][7:0]  pre_q, pre_cnt_q, pre_cnt_d;
    logic [1:0]       en_q, en_d, hw_clr, u_clr, frz;
    logic [1:0]       sync1_q, sync2_q, prev_q, sel_edge;
    logic [1:0]       u_to, u_cm;
    localparam int ST_LAST = timer_pkg::ST_W - 1;
    logic [ST_LAST:0] raw_q, raw_d, masked_q, ev;
    logic             irq_q, trig_q;
    logic [DW-1:0]    div_q;
    logic             tick, clock_adv, to32, clock_ev, clr32;
    logic [2:0]       cfg_prev_q;
    logic [31:0]      wide, wide_load, wide_match, wide_d;
    logic             is16, is32t, is32c;

    assign is16  = (i_width_cfg == timer_pkg::CFG_16_SPLIT);
    assign is32t = (i_width_cfg == timer_pkg::CFG_32_TIMER);
    assign is32c = (i_width_cfg == timer_pkg::CFG_32_CLOCK);
    assign wide       = {cnt_q[1], cnt_q[0]};
    assign wide_load  = {load_q[1], load_q[0]};
    assign wide_match = {match_q[1], match_q[0]};

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detect; first stage feeds only second
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q  <= 2'h0;
        end else if (i_ce) begin
            sync1_q <= i_capture_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-unit 16-bit behaviour
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_unit
            timer_pkg::unit_cfg_s uc;
            logic rise, fall;
            assign uc   = i_unit_cfg[gi];
            assign rise = sync2_q[gi] & ~prev_q[gi];
            assign fall = ~sync2_q[gi] & prev_q[gi];
            assign frz[gi] = i_dbg_halt & uc.debug_stall;
            // Edge selection; input must hold two clocks per level
            assign sel_edge[gi] =
                ((uc.edge_sel == timer_pkg::EDGE_RISE) & rise) |
                ((uc.edge_sel == timer_pkg::EDGE_FALL) & fall) |
                ((uc.edge_sel == timer_pkg::EDGE_BOTH) & (rise | fall));

            // Next count, prescale, events for independent operation
            always_comb begin
                u_cnt_d[gi]   = cnt_q[gi];
                pre_cnt_d[gi] = pre_cnt_q[gi];
                u_to[gi]      = 1'b0;
                u_cm[gi]      = 1'b0;
                u_clr[gi]     = 1'b0;
                if (en_q[gi] && !frz[gi]) begin
                    case (uc.mode)
                        timer_pkg::MODE_ONESHOT,
                        timer_pkg::MODE_PERIODIC: begin
                            if (pre_cnt_q[gi] == timer_pkg::ZERO8) begin
                                pre_cnt_d[gi] = pre_q[gi];
                                if (cnt_q[gi] == timer_pkg::ZERO16) begin
                                    u_cnt_d[gi] = load_q[gi];
                                    u_to[gi]    = 1'b1;
                                    u_clr[gi]   = (uc.mode ==
                                        timer_pkg::MODE_ONESHOT);
                                end else begin
                                    u_cnt_d[gi] = cnt_q[gi] - 16'h0001;
                                end
                            end else begin
                                pre_cnt_d[gi] = pre_cnt_q[gi] - 8'h01;
                            end
                        end
                        timer_pkg::MODE_CAPTURE: begin
                            // Prescaler unused while counting edges
                            if (uc.capture_mode ==
                                timer_pkg::CMR_EDGE_CNT) begin
                                if (cnt_q[gi] == match_q[gi]) begin
                                    u_cm[gi]    = 1'b1;
                                    u_cnt_d[gi] = load_q[gi];
                                    u_clr[gi]   = 1'b1;
                                end else if (sel_edge[gi]) begin
                                    u_cnt_d[gi] = cnt_q[gi] - 16'h0001;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Pin clock divider, only active in clock mode
    assign tick = is32c && en_q[0] && sync2_q[0] && !prev_q[0] &&
                  (div_q == DIV_LAST);
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_q <= '0;
        end else if (i_ce) begin
            if (!is32c || !en_q[0]) begin
                div_q <= '0;
            end else if (sync2_q[0] && !prev_q[0]) begin
                div_q <= (div_q == DIV_LAST) ? '0 : div_q + DW'(1);
            end
        end
    end

    // Override keeps the clock running through a debug halt
    assign clock_adv = tick && !(i_dbg_halt &&
        (i_unit_cfg[0].debug_stall || i_unit_cfg[1].debug_stall) &&
        !i_clock_stall_override);

    ////////////////////////////////////////////////////////////////////
    // Wide count next value and counter register
    always_comb begin
        wide_d   = wide;
        to32     = 1'b0;
        clock_ev = 1'b0;
        clr32    = 1'b0;
        cnt_d    = cnt_q;
        if (is32t) begin
            // Mode taken from half A only
            if (en_q[0] && !frz[0]) begin
                if (wide == timer_pkg::ZERO32) begin
                    wide_d = wide_load;
                    to32   = 1'b1;
                    clr32  = (i_unit_cfg[0].mode ==
                              timer_pkg::MODE_ONESHOT);
                end else begin
                    wide_d = wide - 32'h0000_0001;
                end
            end
            if (i_load_wr[0]) begin
                wide_d = i_wr_data;
            end
            cnt_d = {wide_d[31:16], wide_d[15:0]};
        end else if (is32c) begin
            if (cfg_prev_q != timer_pkg::CFG_32_CLOCK) begin
                wide_d = timer_pkg::CLOCK_START;
            end else if (clock_adv) begin
                if (wide == wide_match) begin
                    wide_d   = timer_pkg::ZERO32;
                    clock_ev = 1'b1;
                end else begin
                    wide_d = wide + 32'h0000_0001;
                end
            end
            cnt_d = {wide_d[31:16], wide_d[15:0]};
        end else if (is16) begin
            for (int i = 0; i < 2; i++) begin
                cnt_d[i] = i_load_wr[i] ? i_wr_data[15:0]
                                        : u_cnt_d[i];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_q      <= {timer_pkg::CNT_RST, timer_pkg::CNT_RST};
            cfg_prev_q <= timer_pkg::CFG_32_TIMER;
        end else if (i_ce) begin
            cnt_q      <= cnt_d;
            cfg_prev_q <= i_width_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Prescale counters run only in split mode
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pre_cnt_q <= {timer_pkg::PRE_RST, timer_pkg::PRE_RST};
        end else if (i_ce && is16) begin
            pre_cnt_q <= pre_cnt_d;
        end
    end

    // Load, match and prescale registers; wide writes split
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            load_q  <= {timer_pkg::LOAD_RST, timer_pkg::LOAD_RST};
            match_q <= {timer_pkg::MATCH_RST, timer_pkg::MATCH_RST};
            pre_q   <= {timer_pkg::PRE_RST, timer_pkg::PRE_RST};
        end else if (i_ce) begin
            if (!is16 && i_load_wr[0]) begin
                load_q[1] <= i_wr_data[31:16];
                load_q[0] <= i_wr_data[15:0];
            end
            if (!is16 && i_match_wr[0]) begin
                match_q[1] <= i_wr_data[31:16];
                match_q[0] <= i_wr_data[15:0];
            end
            for (int i = 0; i < 2; i++) begin
                if (is16 && i_load_wr[i]) begin
                    load_q[i] <= i_wr_data[15:0];
                end
                if (is16 && i_match_wr[i]) begin
                    match_q[i] <= i_wr_data[15:0];
                end
                if (i_prescale_wr[i]) begin
                    pre_q[i] <= i_wr_data[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Enables: software set wins over a hardware stop in one cycle
    assign hw_clr = is16 ? u_clr : {1'b0, clr32};
    assign en_d   = (en_q & ~i_enable_clr & ~hw_clr) | i_enable_set;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            en_q <= 2'h0;
        end else if (i_ce) begin
            en_q <= en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Events into sticky status; a new event beats a clear
    always_comb begin
        ev = '0;
        ev[timer_pkg::ST_TO]      = is16 ? u_to[0] : to32;
        ev[timer_pkg::ST_TO + 1]  = is16 & u_to[1];
        ev[timer_pkg::ST_CM]      = is16 & u_cm[0];
        ev[timer_pkg::ST_CM + 1]  = is16 & u_cm[1];
        ev[timer_pkg::ST_CLOCK]   = clock_ev;
    end
    assign raw_d = (raw_q & ~i_irq_clear) | ev;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            raw_q    <= '0;
            masked_q <= '0;
            irq_q    <= 1'b0;
            trig_q   <= 1'b0;
        end else if (i_ce) begin
            raw_q    <= raw_d;
            masked_q <= raw_d & i_irq_mask;
            irq_q    <= |(raw_d & i_irq_mask);
            trig_q   <= (ev[timer_pkg::ST_TO] &
                         i_unit_cfg[0].trig_en) |
                        (ev[timer_pkg::ST_TO + 1] &
                         i_unit_cfg[1].trig_en);
        end
    end

    // Outputs straight from flops; wide count is B over A
    assign o_unit_enable   = en_q;
    assign o_half_a_count  = cnt_q[0];
    assign o_half_b_count  = cnt_q[1];
    assign o_wide_count    = {cnt_q[1], cnt_q[0]};
    assign o_raw_status    = raw_q;
    assign o_masked_status = masked_q;
    assign o_irq           = irq_q;
    assign o_adc_trig      = trig_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    chk_load_split: assert property (i_ce && !is16 && i_load_wr[0] |=>
        load_q[1] == $past(i_wr_data[31:16]) &&
        load_q[0] == $past(i_wr_data[15:0]))
        else $error("wide load write not split");
    chk_oneshot_stop: assert property (i_ce && is32t && en_q[0] &&
        !frz[0] && wide == timer_pkg::ZERO32 && !i_load_wr[0] &&
        !i_enable_set[0] &&
        i_unit_cfg[0].mode == timer_pkg::MODE_ONESHOT |=>
        !en_q[0] && o_wide_count == $past(wide_load))
        else $error("one-shot did not reload and stop");
    chk_timeout_irq: assert property (i_ce && ev[timer_pkg::ST_TO] &&
        i_irq_mask[timer_pkg::ST_TO] |=> o_irq &&
        o_raw_status[timer_pkg::ST_TO] && o_masked_status[timer_pkg::ST_TO])
        else $error("timeout flags or interrupt missing");
    chk_stall_hold: assert property (i_ce && is32t && frz[0] &&
        !i_load_wr[0] ##1 i_ce && is32t |-> $stable(o_wide_count))
        else $error("counter moved during debug stall");
    chk_clock_first: assert property (i_ce && is32c &&
        cfg_prev_q != timer_pkg::CFG_32_CLOCK |=>
        o_wide_count == timer_pkg::CLOCK_START)
        else $error("clock mode start value wrong");
    chk_clock_roll: assert property (i_ce && is32c &&
        cfg_prev_q == timer_pkg::CFG_32_CLOCK && clock_adv &&
        wide == wide_match |=> o_wide_count == timer_pkg::ZERO32 &&
        o_raw_status[timer_pkg::ST_CLOCK])
        else $error("clock match did not roll over");
    chk_prescale_wait: assert property (i_ce && is16 && en_q[0] &&
        !frz[0] && !i_load_wr[0] && pre_cnt_q[0] != timer_pkg::ZERO8 &&
        i_unit_cfg[0].mode == timer_pkg::MODE_PERIODIC |=>
        o_half_a_count == $past(o_half_a_count))
        else $error("count stepped before prescale expired");
    chk_edge_stop: assert property (i_ce &&
        ev[timer_pkg::ST_CM + 1] && !i_enable_set[1] && !i_load_wr[1] |=>
        !en_q[1] && o_half_b_count == $past(load_q[1]))
        else $error("edge match did not reload and stop");
    chk_trig_gate: assert property (i_ce &&
        !(ev[timer_pkg::ST_TO] && i_unit_cfg[0].trig_en) &&
        !(ev[timer_pkg::ST_TO + 1] && i_unit_cfg[1].trig_en) |=>
        !o_adc_trig)
        else $error("converter trigger without enable");

    cov_periodic_timeout: cover property (is32t && to32 && !clr32);
    cov_clock_match: cover property (clock_ev);
    cov_edge_match: cover property (u_cm[1]);

endmodule

// ==== pin_source.sv ====
// Capture pin source: square wave whose levels each stand several clocks
module pin_source #(
    parameter int HALF = 3
) (
    // Clock and per-pin run requests
    input  wire logic        i_ref_clk,
    input  wire logic [1:0]  i_run,
    // Pin levels and count of edges produced
    output logic [1:0]       o_pin,
    output logic [15:0]      o_edges
);
    timeunit 1ns;
    timeprecision 1ps;

    int          cnt_q = 0;
    logic [1:0]  pin_q = 2'h0;
    logic [15:0] edges_q = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Toggle every HALF clocks; a stopped pin stands still between bursts
    always_ff @(posedge i_ref_clk) begin
        if (cnt_q == HALF - 1) begin
            cnt_q   <= 0;
            pin_q   <= pin_q ^ i_run;
            edges_q <= edges_q + 16'(i_run[0] | i_run[1]);
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end

    // Outputs follow the registered levels
    assign o_pin   = pin_q;
    assign o_edges = edges_q;
endmodule

// ==== tb.sv ====
// Self-checking bench for the dual half timer pair
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DIV = 4;
    logic                       clk;
    logic                       rst;
    logic                       ovr;
    logic                       halt;
    logic                       irq;
    logic                       trig;
    logic                       trig_seen;
    timer_pkg::width_cfg_e      cfg;
    timer_pkg::unit_cfg_s [1:0] ucfg;
    logic [4:0]                 mask, clr, raw, msk;
    logic [1:0]                 en_set, en_clr, ld_wr, m_wr, p_wr;
    logic [1:0]                 run, pin, en;
    logic [31:0]                wdata, wide, hold;
    logic [15:0]                cnt_a, cnt_b, edges;
    logic [1:0]                 sel [3];
    logic [15:0]                exp_b [3];
    int                         fail_count, checks, n;

    ////////////////////////////////////////////////////////////////////////
    // Design and pin source; clock enable tied high
    timer_pair #(.CLOCK_DIV(DIV)) u_timer_pair (
        .i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_width_cfg(cfg),
        .i_unit_cfg(ucfg), .i_clock_stall_override(ovr),
        .i_dbg_halt(halt), .i_irq_mask(mask), .i_enable_set(en_set),
        .i_enable_clr(en_clr), .i_load_wr(ld_wr), .i_match_wr(m_wr),
        .i_prescale_wr(p_wr), .i_wr_data(wdata), .i_irq_clear(clr),
        .i_capture_pin(pin), .o_unit_enable(en), .o_half_a_count(cnt_a),
        .o_half_b_count(cnt_b), .o_wide_count(wide), .o_raw_status(raw),
        .o_masked_status(msk), .o_irq(irq), .o_adc_trig(trig));
    pin_source u_pin_source (.i_ref_clk(clk), .i_run(run), .o_pin(pin),
        .o_edges(edges));

    // Clock and sticky trigger monitor, the pulse lasts one cycle only
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (trig) trig_seen <= 1'b1;

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen,
                     expv);
        end
    endtask
    // One-cycle strobe of one unit with its data word
    task automatic strobe(ref logic [1:0] s, input int u,
                          input logic [31:0] d);
        s[u] = 1'b1;
        wdata = d;
        tick();
        s = 2'h0;
    endtask
    // Bounded wait for a raw status bit; n holds cycles waited
    task automatic wait_bit(int b, int lim);
        n = 0;
        while (raw[b] !== 1'b1 && n < lim) begin
            tick();
            n++;
        end
        chk(32'(n < lim), 32'h1);
    endtask
    task automatic clear_wait(int b, int lim);
        clr = 5'h01 << b;
        tick();
        clr = 5'h00;
        chk(32'(raw[b]), 32'h0);
        wait_bit(b, lim);
    endtask
    // Let the pin source make k edges on pin u, then settle the sync
    task automatic edges_run(int u, int k);
        logic [15:0] e0;
        e0 = edges;
        run[u] = 1'b1;
        for (int i = 0; i < 200 && edges < e0 + 16'(k); i++) tick();
        run = 2'h0;
        tick(5);
    endtask
    task automatic results();
        if (fail_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        results();
    end

    // Main sequence
    initial begin
        rst = 1'b1; ovr = 1'b0; halt = 1'b0; mask = 5'h1F; clr = 5'h00;
        cfg = timer_pkg::CFG_32_TIMER; ucfg = '0; en_set = 2'h0;
        en_clr = 2'h0; ld_wr = 2'h0; m_wr = 2'h0; p_wr = 2'h0;
        run = 2'h0; wdata = 32'h0; trig_seen = 1'b0;
        fail_count = 0; checks = 0;
        sel = '{timer_pkg::EDGE_RISE, timer_pkg::EDGE_FALL,
                timer_pkg::EDGE_BOTH};
        exp_b = '{16'h0008, 16'h0008, 16'h0006};
        tick(3);
        rst = 1'b0;
        chk(wide, 32'hFFFF_FFFF);
        chk(32'({en, raw}), 32'h0);
        // Wide periodic, half B mode left at capture
        ucfg[0].mode = timer_pkg::MODE_PERIODIC;
        ucfg[0].trig_en = 1'b1;
        ucfg[1].mode = timer_pkg::MODE_CAPTURE;
        strobe(ld_wr, 0, 32'h0002_0003);
        chk(32'({cnt_b, cnt_a}), 32'h0002_0003);
        chk(wide, 32'h0002_0003);
        tick();
        strobe(ld_wr, 0, 32'h0000_0003);
        strobe(en_set, 0, 32'h0);
        wait_bit(0, 20);
        chk(wide, 32'h3);
        chk(32'({irq, msk[0], en[0]}), 32'h7);
        tick();
        chk(32'(trig_seen), 32'h1);
        clear_wait(0, 20);
        chk(n, 2);
        strobe(ld_wr, 0, 32'h0000_0100);
        chk(wide, 32'h100);
        // Debugger halt with stall set freezes the count
        ucfg[0].debug_stall = 1'b1;
        halt = 1'b1;
        tick();
        hold = wide;
        tick(5);
        chk(wide, hold);
        halt = 1'b0;
        tick(2);
        chk(32'(wide < hold), 32'h1);
        // Wide one-shot without trigger
        strobe(en_clr, 0, 32'h0);
        ucfg[0] = '0;
        ucfg[0].mode = timer_pkg::MODE_ONESHOT;
        clr = 5'h1F;
        tick();
        clr = 5'h00;
        trig_seen = 1'b0;
        strobe(ld_wr, 0, 32'h5);
        strobe(en_set, 0, 32'h0);
        wait_bit(0, 20);
        chk(wide, 32'h5);
        chk(32'(en[0]), 32'h0);
        tick(3);
        chk(wide, 32'h5);
        chk(32'(trig_seen), 32'h0);
        // Two independent 16-bit units, A with prescale 2
        cfg = timer_pkg::CFG_16_SPLIT;
        ucfg[0].mode = timer_pkg::MODE_PERIODIC;
        ucfg[1].mode = timer_pkg::MODE_PERIODIC;
        strobe(p_wr, 0, 32'h2);
        strobe(ld_wr, 0, 32'h5);
        tick();
        strobe(ld_wr, 1, 32'h3);
        chk(32'({cnt_b, cnt_a}), 32'h0003_0005);
        en_set = 2'h3;
        tick();
        en_set = 2'h0;
        clear_wait(1, 20);
        clear_wait(1, 20);
        chk(n, 3);
        clear_wait(0, 40);
        clear_wait(0, 40);
        chk(n, 17);
        // Edge counting on half B for each edge selection
        ucfg[1].mode = timer_pkg::MODE_CAPTURE;
        ucfg[1].capture_mode = timer_pkg::CMR_EDGE_CNT;
        for (int i = 0; i < 3; i++) begin
            ucfg[1].edge_sel = sel[i];
            strobe(ld_wr, 1, 32'hA);
            strobe(m_wr, 1, 32'h0);
            strobe(en_set, 1, 32'h0);
            edges_run(1, 4);
            chk(cnt_b, exp_b[i]);
            strobe(en_clr, 1, 32'h0);
        end
        // Match after four edges; the last two are ignored
        strobe(ld_wr, 1, 32'hA);
        strobe(m_wr, 1, 32'h6);
        strobe(en_set, 1, 32'h0);
        edges_run(1, 6);
        chk(32'({raw[3], msk[3], en[1], cnt_b}), 32'h6_000A);
        // Clock mode, counting through a halt with the override
        en_clr = 2'h3;
        tick();
        en_clr = 2'h0;
        cfg = timer_pkg::CFG_32_CLOCK;
        tick(2);
        chk(wide, 32'h1);
        strobe(m_wr, 0, 32'h3);
        ovr = 1'b1;
        ucfg[0].debug_stall = 1'b1;
        halt = 1'b1;
        strobe(en_set, 0, 32'h0);
        run = 2'h1;
        wait_bit(4, 400);
        chk(32'(n >= 60 && n <= 84), 32'h1);
        chk(wide, 32'h0);
        chk(32'({irq, msk[4]}), 32'h3);
        // Keeps counting after the roll and matches again
        clear_wait(4, 120);
        run = 2'h0;
        results();
    end
endmodule
